// *** src/ierr_pkg.sv ***
// Constants, offsets and types for the internal error mask register block
`default_nettype none

package ierr_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 12;                     // Byte address width
  localparam int DATA_W = 32;                     // Register data width
  localparam int STRB_W = 4;                      // Byte lanes
  localparam int ERR_W  = 19;                     // Implemented error bits 18..0
  localparam int IRQ_W  = 2;                      // Interrupt event bits

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] STATUS_OFS     = 12'h484; // internal_error_status
  localparam logic [ADDR_W-1:0] MASK_OFS       = 12'h488; // internal_error_report_mask
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h4a0; // Interrupt event status
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS   = 12'h4a4; // Interrupt event mask

  // ****************************************************************
  // Reset values and field layout
  // ****************************************************************
  localparam logic [DATA_W-1:0] REG_RESET  = 32'h0000_0000; // All unmasked, all clear
  localparam logic [DATA_W-1:0] VALID_BITS = 32'h0007_fff7; // Bit 3, 31..19 reserved
  localparam logic [IRQ_W-1:0]  IRQ_RESET  = 2'h0;          // Interrupt regs after reset

  // Field positions, shared by status and mask
  localparam int INGRESS_POSTED_TIMEOUT_BIT     = 0;
  localparam int INGRESS_COMPLETION_TIMEOUT_BIT = 2;
  localparam int RESERVED_BIT                   = 3;
  localparam int EGRESS_POSTED_TIMEOUT_BIT      = 4;
  localparam int EGRESS_COMPLETION_TIMEOUT_BIT  = 6;
  localparam int INGRESS_DATA_SINGLE_ECC_BIT    = 7;
  localparam int INGRESS_CTRL_DOUBLE_ECC_BIT    = 10;
  localparam int EGRESS_DATA_SINGLE_ECC_BIT     = 11;
  localparam int EGRESS_CTRL_DOUBLE_ECC_BIT     = 14;
  localparam int END_TO_END_PARITY_BIT          = 15;
  localparam int UNRELIABLE_LINK_BIT            = 16;
  localparam int REPLAY_CTRL_SINGLE_ECC_BIT     = 17;
  localparam int REPLAY_CTRL_DOUBLE_ECC_BIT     = 18;

  // Interrupt event positions
  localparam int IRQ_REPORT_BIT = 0;              // A new unmasked report started
  localparam int IRQ_MASKED_BIT = 1;              // An error was captured while masked

  // ****************************************************************
  // Bus answers and handshake states
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_TAKE = 2'b01,
    WR_RESP = 2'b11
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_TAKE = 2'b01,
    RD_RESP = 2'b11
  } rd_state_t;

endpackage

`default_nettype wire

// *** src/err_bank_if.sv ***
// Connection between the bus front end and the sticky error bit bank
`default_nettype none

interface err_bank_if;
  import ierr_pkg::*;

  logic              mask_wr;    // One-cycle mask write strobe
  logic [DATA_W-1:0] wr_data;    // Write data, reserved bits stripped; lanes gated by wr_bits
  logic [DATA_W-1:0] wr_bits;    // Bits covered by the byte strobes
  logic [DATA_W-1:0] status_clr; // Write-one-to-clear pattern
  logic [DATA_W-1:0] err_set;    // Error detect pulses
  logic [DATA_W-1:0] mask;       // Current mask register
  logic [DATA_W-1:0] status;     // Current status register

  modport ctrl (output mask_wr, wr_data, wr_bits, status_clr, err_set,
                input  mask, status);
  modport bank (input  mask_wr, wr_data, wr_bits, status_clr, err_set,
                output mask, status);
endinterface

`default_nettype wire

// *** src/error_bit_bank.sv ***
// Sticky per-error status and mask bits, one slice per error type
`default_nettype none

module error_bit_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Front end
  err_bank_if.bank bus
);
  import ierr_pkg::*;

  // ****************************************************************
  // Bit slices
  // ****************************************************************
  // Only power-on reset reaches these flops; a soft reset never does,
  // which is what keeps them sticky.
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_bit
      if (VALID_BITS[i]) begin : g_live
        // Mask: plain read-write bit
        always_ff @(posedge clk_sys or negedge rst_n) begin
          if (!rst_n) begin
            bus.mask[i] <= REG_RESET[i];
          end else if (bus.mask_wr && bus.wr_bits[i]) begin
            bus.mask[i] <= bus.wr_data[i];
          end
        end

        // Status: capture is independent of the mask, set beats clear
        always_ff @(posedge clk_sys or negedge rst_n) begin
          if (!rst_n) begin
            bus.status[i] <= REG_RESET[i];
          end else begin
            bus.status[i] <= bus.err_set[i] | (bus.status[i] & ~bus.status_clr[i]);
          end
        end

        status_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
          bus.err_set[i] |=> bus.status[i])
          else $error("status bit missed its error event");

        status_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
          bus.status_clr[i] && !bus.err_set[i] |=> !bus.status[i])
          else $error("status bit survived write-one clear");
      end else begin : g_rsvd
        // Reserved positions have no storage and read zero
        assign bus.mask[i]   = 1'b0;
        assign bus.status[i] = 1'b0;
      end
    end
  endgenerate

endmodule

`default_nettype wire

// *** src/internal_error_report_mask.sv ***
// AXI4-Lite register block gating captured internal errors onto the report
// Contract
// - Set mask bit blocks that error's report
// - Masking never changes capture or clearing
// - Mask fields read-write, reset zero, sticky
// - Bits 4-6 mask egress timeouts
// - Bits 7-10 mask ingress ECC errors
// - Bits 11-14 mask egress ECC errors
// - Bit 15 parity, bit 16 unreliable link
// - Bits 17-18 mask replay ECC errors
// - Bits 0-2 ingress timeouts, bit 3 zero
// - Status set by error, cleared writing one
`default_nettype none

module internal_error_report_mask (
  // Clock and reset
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST_N,
  input  wire logic                      SOFT_RST,
  // Error detectors
  input  wire logic [ierr_pkg::ERR_W-1:0] ERR_DETECT,
  // AXI4-Lite write address and data
  input  wire logic                      AWVALID,
  output logic                           AWREADY,
  input  wire logic [ierr_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                      WVALID,
  output logic                           WREADY,
  input  wire logic [ierr_pkg::DATA_W-1:0] WDATA,
  input  wire logic [ierr_pkg::STRB_W-1:0] WSTRB,
  // AXI4-Lite write response
  output logic                           BVALID,
  input  wire logic                      BREADY,
  output logic [1:0]                     BRESP,
  // AXI4-Lite read
  input  wire logic                      ARVALID,
  output logic                           ARREADY,
  input  wire logic [ierr_pkg::ADDR_W-1:0] ARADDR,
  output logic                           RVALID,
  input  wire logic                      RREADY,
  output logic [ierr_pkg::DATA_W-1:0]    RDATA,
  output logic [1:0]                     RRESP,
  // Error reporting side
  output logic [ierr_pkg::ERR_W-1:0]     REPORT_VEC,
  output logic                           INTERNAL_ERR_REPORT,
  // Interrupt
  output logic                           IRQ
);
  import ierr_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wr_state_t         wr_state;        // Write handshake state
  rd_state_t         rd_state;        // Read handshake state
  logic              wr_fire;         // Write is performed this cycle
  logic              wr_hit_status;   // Write targets status
  logic              wr_hit_mask;     // Write targets mask
  logic              wr_hit_irq_sts;  // Write targets interrupt status
  logic              wr_hit_irq_msk;  // Write targets interrupt mask
  logic              wr_mapped;       // Write address decodes
  logic [DATA_W-1:0] byte_bits;       // Byte strobes widened to bits
  logic [DATA_W-1:0] next_rdata;      // Read mux result
  logic              rd_mapped;       // Read address decodes
  logic [ERR_W-1:0]  next_report_vec; // Unmasked, captured errors
  logic [IRQ_W-1:0]  irq_status;      // Sticky interrupt events
  logic [IRQ_W-1:0]  irq_mask;        // Interrupt enables, one per event
  logic [IRQ_W-1:0]  irq_set;         // Interrupt events this cycle
  logic [IRQ_W-1:0]  irq_clr;         // Interrupt write-one clears
  logic [IRQ_W-1:0]  next_irq_status; // Interrupt status after this edge
  logic [IRQ_W-1:0]  next_irq_mask;   // Interrupt mask after this edge

  err_bank_if bank_if ();

  // ****************************************************************
  // Sticky bit bank
  // ****************************************************************
  error_bit_bank u_bank (
    .clk_sys (CLK_SYS),
    .rst_n   (RST_N),
    .bus     (bank_if.bank)
  );

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // Address and data are sampled in WR_TAKE, the handshake cycle, while the
  // master still holds them, so no holding register is needed.
  always_comb begin
    wr_fire        = (wr_state == WR_TAKE);
    wr_hit_status  = (AWADDR[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2]);
    wr_hit_mask    = (AWADDR[ADDR_W-1:2] == MASK_OFS[ADDR_W-1:2]);
    wr_hit_irq_sts = (AWADDR[ADDR_W-1:2] == IRQ_STATUS_OFS[ADDR_W-1:2]);
    wr_hit_irq_msk = (AWADDR[ADDR_W-1:2] == IRQ_MASK_OFS[ADDR_W-1:2]);
    wr_mapped      = wr_hit_status | wr_hit_mask | wr_hit_irq_sts | wr_hit_irq_msk;
    byte_bits      = {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
  end

  // Drive the bank; reserved bits are stripped here and in the bank
  always_comb begin
    bank_if.mask_wr    = wr_fire & wr_hit_mask;
    bank_if.wr_data    = WDATA & VALID_BITS;
    bank_if.wr_bits    = byte_bits & VALID_BITS;
    bank_if.status_clr = (wr_fire & wr_hit_status) ? (WDATA & byte_bits & VALID_BITS)
                                                   : REG_RESET;
    bank_if.err_set    = {{(DATA_W-ERR_W){1'b0}}, ERR_DETECT} & VALID_BITS;
  end

  // ****************************************************************
  // Write handshake
  // ****************************************************************
  // Both channels are taken together: the slave waits for address and data,
  // then raises both readies for exactly one cycle.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wr_state <= WR_IDLE;
      AWREADY  <= 1'b0;
      WREADY   <= 1'b0;
      BVALID   <= 1'b0;
      BRESP    <= RESP_OKAY;
    end else begin
      unique case (wr_state)
        WR_IDLE: begin
          // Wait for both halves of the write
          if (AWVALID && WVALID) begin
            wr_state <= WR_TAKE;
            AWREADY  <= 1'b1;
            WREADY   <= 1'b1;
          end
        end
        WR_TAKE: begin
          // Handshake edge; the register write lands here
          wr_state <= WR_RESP;
          AWREADY  <= 1'b0;
          WREADY   <= 1'b0;
          BVALID   <= 1'b1;
          BRESP    <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        WR_RESP: begin
          // Hold the answer until the master takes it
          if (BREADY) begin
            wr_state <= WR_IDLE;
            BVALID   <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Read handshake and data
  // ****************************************************************
  always_comb begin
    rd_mapped  = 1'b1;
    next_rdata = REG_RESET;
    unique case (ARADDR[ADDR_W-1:2])
      STATUS_OFS[ADDR_W-1:2]:     next_rdata = bank_if.status;
      MASK_OFS[ADDR_W-1:2]:       next_rdata = bank_if.mask;
      IRQ_STATUS_OFS[ADDR_W-1:2]: next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
      IRQ_MASK_OFS[ADDR_W-1:2]:   next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
      default:                    rd_mapped  = 1'b0;
    endcase
  end

  // Reads are side-effect free; RDATA is zero for an unmapped address
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rd_state <= RD_IDLE;
      ARREADY  <= 1'b0;
      RVALID   <= 1'b0;
      RDATA    <= REG_RESET;
      RRESP    <= RESP_OKAY;
    end else begin
      unique case (rd_state)
        RD_IDLE: begin
          if (ARVALID) begin
            rd_state <= RD_TAKE;
            ARREADY  <= 1'b1;
          end
        end
        RD_TAKE: begin
          rd_state <= RD_RESP;
          ARREADY  <= 1'b0;
          RVALID   <= 1'b1;
          RDATA    <= next_rdata;
          RRESP    <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        RD_RESP: begin
          if (RREADY) begin
            rd_state <= RD_IDLE;
            RVALID   <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Error report towards the reporting logic
  // ****************************************************************
  // One register stage: a report follows its status bit by one cycle and
  // drops one cycle after the bit is masked or cleared.
  always_comb begin
    next_report_vec = bank_if.status[ERR_W-1:0] & ~bank_if.mask[ERR_W-1:0];
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REPORT_VEC          <= '0;
      INTERNAL_ERR_REPORT <= 1'b0;
    end else begin
      REPORT_VEC          <= next_report_vec;
      INTERNAL_ERR_REPORT <= |next_report_vec;
    end
  end

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  // These two registers are not sticky: a soft reset clears them, but an
  // event in the same cycle still wins.
  always_comb begin
    irq_set[IRQ_REPORT_BIT] = (|next_report_vec) & ~INTERNAL_ERR_REPORT;
    irq_set[IRQ_MASKED_BIT] = |(bank_if.err_set[ERR_W-1:0] & bank_if.mask[ERR_W-1:0]);
    irq_clr = (wr_fire && wr_hit_irq_sts) ? (WDATA[IRQ_W-1:0] & byte_bits[IRQ_W-1:0])
                                          : IRQ_RESET;
    // Set beats clear; a soft reset clears both registers
    next_irq_status = irq_set | (irq_status & ~irq_clr & ~{IRQ_W{SOFT_RST}});
    next_irq_mask   = irq_mask;
    if (SOFT_RST) begin
      next_irq_mask = IRQ_RESET;
    end else if (wr_fire && wr_hit_irq_msk && WSTRB[0]) begin
      next_irq_mask = WDATA[IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_mask <= IRQ_RESET;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // Level output from the next state, so it moves with status and mask;
  // a disabled event must never raise it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_irq_status & next_irq_mask);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  mask_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ##1 (REPORT_VEC & $past(bank_if.mask[ERR_W-1:0])) == '0)
    else $error("masked error reached the report");

  status_kept_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    bank_if.mask_wr && ERR_DETECT == '0 |=> $stable(bank_if.status))
    else $error("mask write disturbed status");

  mask_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SOFT_RST && !bank_if.mask_wr |=> $stable(bank_if.mask))
    else $error("soft reset disturbed the mask");

  mask_readback_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    rd_state == RD_TAKE && ARADDR[ADDR_W-1:2] == MASK_OFS[ADDR_W-1:2]
    |=> RVALID && RDATA == $past(bank_if.mask))
    else $error("mask read returned wrong value");

  egress_timeout_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ##1 REPORT_VEC[EGRESS_COMPLETION_TIMEOUT_BIT:EGRESS_POSTED_TIMEOUT_BIT] ==
    $past(bank_if.status[6:4] & ~bank_if.mask[6:4]))
    else $error("egress timeout report misrouted");

  ingress_ecc_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    bank_if.status[10:7] == 4'hf && bank_if.mask[10:7] == 4'h0
    |=> REPORT_VEC[INGRESS_CTRL_DOUBLE_ECC_BIT:INGRESS_DATA_SINGLE_ECC_BIT] == 4'hf)
    else $error("ingress ecc report misrouted");

  egress_ecc_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    bank_if.mask[14:11] == 4'hf |=>
    REPORT_VEC[EGRESS_CTRL_DOUBLE_ECC_BIT:EGRESS_DATA_SINGLE_ECC_BIT] == 4'h0)
    else $error("egress ecc report not masked");

  parity_link_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ##1 REPORT_VEC[UNRELIABLE_LINK_BIT:END_TO_END_PARITY_BIT] ==
    $past(bank_if.status[16:15] & ~bank_if.mask[16:15]))
    else $error("parity or link report misrouted");

  replay_ecc_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ERR_DETECT[REPLAY_CTRL_DOUBLE_ECC_BIT] && !bank_if.mask[18] ##1 !bank_if.mask[18]
    |=> REPORT_VEC[REPLAY_CTRL_DOUBLE_ECC_BIT])
    else $error("replay ecc report missing");

  ingress_timeout_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    |ERR_DETECT[INGRESS_COMPLETION_TIMEOUT_BIT:INGRESS_POSTED_TIMEOUT_BIT]
    |=> (bank_if.status[2:0] & $past(ERR_DETECT[2:0])) == $past(ERR_DETECT[2:0]) &&
        bank_if.mask[RESERVED_BIT] == 1'b0 && bank_if.status[RESERVED_BIT] == 1'b0)
    else $error("ingress timeout bits wrong");

  reserved_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    bank_if.mask[DATA_W-1:ERR_W] == '0 && bank_if.status[DATA_W-1:ERR_W] == '0)
    else $error("reserved bits not zero");

endmodule

`default_nettype wire

// *** testbench/err_far_model.sv ***
// Far-side model: the error detectors and the report sink of the block
`default_nettype none

module err_far_model (
  // Clock
  input  wire logic                       clk_sys,
  // Report side of the block
  input  wire logic [ierr_pkg::ERR_W-1:0] report_vec,
  input  wire logic                       report_any,
  // Detector pulses into the block
  output logic      [ierr_pkg::ERR_W-1:0] err_detect
);
  import ierr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Detector side
  // ****************************************************************
  logic [ERR_W-1:0] seen;  // Every report bit shown since the last clear

  // Quiet detectors from time zero
  initial begin
    err_detect = '0;
    seen       = '0;
  end

  // One-cycle detect pulse, launched right after a rising edge
  task automatic pulse(input logic [ERR_W-1:0] bits);
    err_detect <= bits;
    @(posedge clk_sys);
    err_detect <= '0;
  endtask

  // ****************************************************************
  // Report sink
  // ****************************************************************
  // Accumulate reports so that even a one-cycle glitch is not missed
  always @(posedge clk_sys) begin
    if (report_any === 1'b1) begin
      seen <= seen | report_vec;
    end
  end

  // Forget what was reported so far
  task automatic clear_seen;
    seen <= '0;
  endtask
endmodule

`default_nettype wire

// *** testbench/tb_internal_error_report_mask.sv ***
// Testbench: register access, error masking and interrupts of the mask block
`default_nettype none

module tb_internal_error_report_mask;
  import ierr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic              clk_sys, rst_n, soft_rst;        // Clock and resets
  logic              awvalid, wvalid, bready;         // Write requests
  logic              arvalid, rready;                 // Read requests
  logic              awready, wready, bvalid;         // Write answers
  logic              arready, rvalid, report_any, irq;
  logic [ADDR_W-1:0] awaddr, araddr;                  // Addresses
  logic [DATA_W-1:0] wdata, rdata;                    // Data
  logic [STRB_W-1:0] wstrb;                           // Byte lanes
  logic [1:0]        bresp, rresp, r;                 // Responses, last one
  logic [ERR_W-1:0]  err_detect, report_vec;          // Error side
  logic [DATA_W-1:0] d, e, b;                         // Read value, expected
  int                errors, total_checks;            // Verdict counters

  internal_error_report_mask DUT (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .SOFT_RST(soft_rst), .ERR_DETECT(err_detect),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
    .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready),
    .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
    .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
    .REPORT_VEC(report_vec), .INTERNAL_ERR_REPORT(report_any), .IRQ(irq));

  err_far_model far (.clk_sys(clk_sys), .report_vec(report_vec),
    .report_any(report_any), .err_detect(err_detect));

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Compare and count; an unknown matches only an unknown
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Write one word; readies are looked at mid-cycle, released after the edge;
  // bready stays up between calls so no signal is driven twice in one step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                    input logic [STRB_W-1:0] s);
    logic aw, w, bv;
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= s;
    bready  <= 1'b1;
    do begin
      @(negedge clk_sys);
      aw = (awready === 1'b1);
      w  = (wready === 1'b1);
      bv = (bvalid === 1'b1);
      r  = bresp;
      @(posedge clk_sys);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!bv);
  endtask

  // Read one word into d, its response into r
  task automatic rd(input logic [ADDR_W-1:0] a);
    logic ar, rv;
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(negedge clk_sys);
      ar = (arready === 1'b1);
      rv = (rvalid === 1'b1);
      d  = rdata;
      r  = rresp;
      @(posedge clk_sys);
      if (ar) arvalid <= 1'b0;
    end while (!rv);
  endtask

  // Look at report and interrupt outputs in the middle of this cycle
  task automatic look(input logic [ERR_W-1:0] ev, input logic ei);
    @(negedge clk_sys);
    chk({11'h0, irq, report_any, report_vec}, {11'h0, ei, |ev, ev});
    @(posedge clk_sys);
  endtask

  // Verdict and end of run
  task automatic summarize;
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    soft_rst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    errors = 0;
    total_checks = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(MASK_OFS);
    chk(d, REG_RESET);
    rd(STATUS_OFS);
    chk(d, REG_RESET);
    wr(MASK_OFS, '1, 4'hf);
    chk(DATA_W'(r), DATA_W'(RESP_OKAY));
    rd(MASK_OFS);
    chk(d, VALID_BITS);
    // Lane 0 only: upper lanes must keep their ones
    wr(MASK_OFS, '0, 4'h1);
    rd(MASK_OFS);
    chk(d, VALID_BITS & 32'hffff_ff00);
    wr(MASK_OFS, '0, 4'hf);
    // Each error bit against its own mask bit; bit 3 must stay silent
    for (int i = 0; i < ERR_W; i++) begin
      b = 32'h1 << i;
      e = VALID_BITS & b;
      far.pulse(b[ERR_W-1:0]);
      @(posedge clk_sys);
      look(e[ERR_W-1:0], 1'b0);
      wr(MASK_OFS, b, 4'hf);
      look('0, 1'b0);
      rd(STATUS_OFS);
      chk(d, e);
      rd(MASK_OFS);
      chk(d, e);
      far.clear_seen();
      far.pulse(b[ERR_W-1:0]);
      repeat (3) @(posedge clk_sys);
      chk(DATA_W'(far.seen), '0);
      wr(STATUS_OFS, b, 4'hf);
      rd(STATUS_OFS);
      chk(d, '0);
      wr(MASK_OFS, '0, 4'hf);
    end
    // All errors at once, all masked at once, then cleared again
    far.pulse('1);
    @(posedge clk_sys);
    look(VALID_BITS[ERR_W-1:0], 1'b0);
    wr(MASK_OFS, '1, 4'hf);
    look('0, 1'b0);
    wr(STATUS_OFS, '1, 4'hf);
    wr(MASK_OFS, '0, 4'hf);
    rd(STATUS_OFS);
    chk(d, '0);
    // Interrupt: both events were seen above, then enable, clear, mask
    rd(IRQ_STATUS_OFS);
    chk(d, 32'h3);
    wr(IRQ_MASK_OFS, 32'h3, 4'hf);
    look('0, 1'b1);
    wr(IRQ_STATUS_OFS, 32'h3, 4'hf);
    look('0, 1'b0);
    far.pulse(19'h1);
    @(posedge clk_sys);
    look(19'h1, 1'b1);
    wr(IRQ_MASK_OFS, '0, 4'hf);
    look(19'h1, 1'b0);
    // Software reset must spare mask and status
    wr(MASK_OFS, 32'h2, 4'hf);
    soft_rst <= 1'b1;
    @(posedge clk_sys);
    soft_rst <= 1'b0;
    rd(MASK_OFS);
    chk(d, 32'h2);
    rd(STATUS_OFS);
    chk(d, 32'h1);
    rd(IRQ_STATUS_OFS);
    chk(d, '0);
    // Unmapped address: error answer, no side effect
    rd(12'h000);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(12'h000, '1, 4'hf);
    chk(DATA_W'(r), DATA_W'(RESP_SLVERR));
    rd(MASK_OFS);
    chk(d, 32'h2);
    summarize();
  end

  // Watchdog well beyond the expected run of about 600 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("FAIL %0t watchdog expired", $time);
    summarize();
  end
endmodule

`default_nettype wire
